// ===== rtl/tof_error_timeout_clock_regs.sv
// Purpose: Echo error flags, timeout and clock rate registers with their tick timing
// Assumes: Avalon-MM slave with waitrequest; event inputs synchronous to clock_in
// Notes: Each access answers on the second edge; unmapped reads return zero
`timescale 1ns/1ps
`include "tof_regs_cfg.svh"

// Summary of operation
// - A listening timeout with fewer qualified crossings than expected sets the weak-echo flag.
// - A listening timeout with no signal received sets the missing-echo flag.
// - Writing one to the missing-echo bit resets the sequence and aborts any measurement.
// - The strong-echo flag is set by an over-threshold echo only while the threshold code is maximal.
// - Writing one to the strong-echo bit clears all error flags and releases the fault pin.
// - With the short-flight force bit set the sequence runs a short-flight blanking phase.
// - The blanking field selects 8 base ticks times two to the code, default code 3.
// - The echo-wait bit enables the listening timeout at zero and disables it at one.
// - The listening window field selects 128, 256, 512 or 1024 base ticks, default code 1.
// - The clock divider bit makes the base tick the clock divided by one or by two.
// - The offset-cancel field selects 64, 128, 256 or 512 base ticks, default code 0.
module tof_error_timeout_clock_regs
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [5:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic meas_start_in,
   input wire logic echo_qualified_in,
   input wire logic echo_signal_in,
   input wire logic amplitude_over_in,
   input wire logic [2:0] echo_threshold_select_in,
   input wire logic [2:0] expected_crossings_in,
   output logic fault_out_n,
   output logic irq_out,
   output logic timeout_out,
   output logic state_reset_out,
   output logic short_flight_force_out,
   output logic busy_out
);

   localparam tof_regs_pkg::regs_state_type RESET_STATE = '{
      timeout_control: `TIMEOUT_RST,
      clock_rate_control: `CLK_RATE_RST,
      flags: `FLAGS_RST,
      irq_status: `IRQ_RST,
      irq_mask: `IRQ_RST,
      phase: tof_regs_pkg::phase_idle,
      crossings: 3'h0,
      signal_seen: 1'b0,
      waitrequest: 1'b1,
      readdata: `READDATA_RST,
      fault_n: 1'b1,
      irq: 1'b0,
      state_reset: 1'b0,
      timeout: 1'b0,
      short_force: 1'b0,
      busy: 1'b0,
      timer_start: 1'b0,
      timer_abort: 1'b0,
      timer_length: 11'h000
   };

   tof_regs_pkg::regs_state_type s_r;
   tof_regs_pkg::regs_state_type s_nxt;
   logic timer_done;
   logic [3:0] index;
   logic request;
   logic accept;
   logic wr_ok;
   logic rd_ok;
   logic clr_all;
   logic clr_missing;
   logic start_req;
   logic wait_en;
   logic [3:0] crossings_plus;
   logic [2:0] flag_set;
   logic [2:0] irq_set;

   // Register index from the byte address
   function automatic logic [3:0] reg_index(input logic [5:0] addr);
      reg_index = addr[5:2];
   endfunction

   // Tick count for a code, scaled from its base count
   function automatic logic [10:0] ticks(input logic [10:0] base, input logic [2:0] code);
      ticks = base << code;
   endfunction

   // Read word of a register, zero for unmapped indices
   function automatic logic [31:0] read_word(input logic [3:0] idx, input tof_regs_pkg::regs_state_type st);
      case (idx)
         `ERR_FLAGS_IDX: read_word = {29'h0000_0000, st.flags};
         `TIMEOUT_IDX: read_word = {24'h00_0000, st.timeout_control};
         `CLK_RATE_IDX: read_word = {24'h00_0000, st.clock_rate_control};
         `IRQ_STATUS_IDX: read_word = {29'h0000_0000, st.irq_status};
         `IRQ_MASK_IDX: read_word = {29'h0000_0000, st.irq_mask};
         `MEAS_CTRL_IDX: read_word = {28'h000_0000, st.busy, st.phase};
         default: read_word = `READDATA_RST;
      endcase
   endfunction

   // Bus decode: request taken on the edge that sees waitrequest low
   assign index = reg_index(address_in);
   assign request = read_in || write_in;
   assign accept = request && !s_r.waitrequest;
   assign wr_ok = accept && write_in && byteenable_in[0];
   assign rd_ok = accept && read_in;
   assign clr_all = wr_ok && (index == `ERR_FLAGS_IDX) && writedata_in[`ERR_STRONG_BIT];
   assign clr_missing = wr_ok && (index == `ERR_FLAGS_IDX) && writedata_in[`ERR_MISSING_BIT];
   assign start_req = meas_start_in || (wr_ok && (index == `MEAS_CTRL_IDX) && writedata_in[`MC_START_BIT]);
   assign wait_en = !s_r.timeout_control[`TO_WAIT_BIT];
   assign crossings_plus = {1'b0, s_r.crossings} + 4'h1;

   // Base tick timer shared by all phases
   tick_timer timer_inst
   (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .halve_in(s_r.clock_rate_control[`CR_HALVE_BIT]),
      .start_in(s_r.timer_start),
      .abort_in(s_r.timer_abort),
      .length_in(s_r.timer_length),
      .done_out(timer_done)
   );

   // Next state: bus, sequence, flags and interrupts
   always_comb
   begin
      s_nxt = s_r;
      flag_set = 3'h0;
      irq_set = 3'h0;
      s_nxt.state_reset = 1'b0;
      s_nxt.timeout = 1'b0;
      s_nxt.timer_start = 1'b0;
      s_nxt.timer_abort = 1'b0;
      s_nxt.waitrequest = !(request && s_r.waitrequest);
      if (request && s_r.waitrequest && read_in)
      begin
         s_nxt.readdata = read_word(index, s_r);
      end
      // Register writes
      if (wr_ok)
      begin
         case (index)
            `TIMEOUT_IDX: s_nxt.timeout_control = writedata_in[7:0];
            `CLK_RATE_IDX: s_nxt.clock_rate_control = writedata_in[7:0];
            `IRQ_MASK_IDX: s_nxt.irq_mask = writedata_in[2:0];
            default: s_nxt.irq_mask = s_r.irq_mask;
         endcase
      end
      // Measurement sequence
      case (s_r.phase)
         tof_regs_pkg::phase_idle:
         begin
            if (start_req)
            begin
               s_nxt.crossings = 3'h0;
               s_nxt.signal_seen = 1'b0;
               s_nxt.phase = tof_regs_pkg::phase_cancel;
               s_nxt.timer_start = 1'b1;
               s_nxt.timer_length = ticks(`CANCEL_BASE_TICKS,
                  {1'b0, s_r.clock_rate_control[`CR_CANCEL_LSB +: 2]});
            end
         end
         tof_regs_pkg::phase_cancel:
         begin
            if (timer_done)
            begin
               s_nxt.timer_start = 1'b1;
               if (s_r.timeout_control[`TO_FORCE_BIT])
               begin
                  s_nxt.phase = tof_regs_pkg::phase_blank;
                  s_nxt.timer_length = ticks(`BLANK_BASE_TICKS, s_r.timeout_control[`TO_BLANK_LSB +: 3]);
               end
               else
               begin
                  s_nxt.phase = tof_regs_pkg::phase_listen;
                  s_nxt.timer_length = ticks(`LISTEN_BASE_TICKS,
                     {1'b0, s_r.timeout_control[`TO_LISTEN_LSB +: 2]});
               end
            end
         end
         tof_regs_pkg::phase_blank:
         begin
            if (timer_done)
            begin
               s_nxt.phase = tof_regs_pkg::phase_listen;
               s_nxt.timer_start = 1'b1;
               s_nxt.timer_length = ticks(`LISTEN_BASE_TICKS,
                  {1'b0, s_r.timeout_control[`TO_LISTEN_LSB +: 2]});
            end
         end
         tof_regs_pkg::phase_listen:
         begin
            if (echo_signal_in || echo_qualified_in)
            begin
               s_nxt.signal_seen = 1'b1;
            end
            if (echo_qualified_in && s_r.crossings != 3'h7)
            begin
               s_nxt.crossings = crossings_plus[2:0];
            end
            if (echo_qualified_in && crossings_plus >= {1'b0, expected_crossings_in})
            begin
               s_nxt.phase = tof_regs_pkg::phase_idle;
               s_nxt.timer_abort = 1'b1;
               irq_set[`IRQ_DONE_BIT] = 1'b1;
            end
            else if (timer_done && wait_en)
            begin
               s_nxt.phase = tof_regs_pkg::phase_idle;
               s_nxt.timeout = 1'b1;
               irq_set[`IRQ_TIMEOUT_BIT] = 1'b1;
               flag_set[`ERR_WEAK_BIT] = s_r.crossings < expected_crossings_in;
               flag_set[`ERR_MISSING_BIT] = !s_r.signal_seen;
            end
         end
         default:
         begin
            s_nxt.phase = tof_regs_pkg::phase_idle;
         end
      endcase
      // Missing-echo clear aborts the sequence
      if (clr_missing)
      begin
         s_nxt.phase = tof_regs_pkg::phase_idle;
         s_nxt.state_reset = 1'b1;
         s_nxt.timer_abort = 1'b1;
         s_nxt.timer_start = 1'b0;
         s_nxt.timeout = 1'b0;
         flag_set[`ERR_WEAK_BIT] = 1'b0;
         flag_set[`ERR_MISSING_BIT] = 1'b0;
         irq_set[`IRQ_TIMEOUT_BIT] = 1'b0;
      end
      // Strong echo only at the highest threshold code
      flag_set[`ERR_STRONG_BIT] = amplitude_over_in && (echo_threshold_select_in == `THRESH_MAX);
      // Flag clears, new events win
      if (clr_all)
      begin
         s_nxt.flags = `FLAGS_RST;
      end
      else if (clr_missing)
      begin
         s_nxt.flags[`ERR_MISSING_BIT] = 1'b0;
      end
      s_nxt.flags = s_nxt.flags | flag_set;
      irq_set[`IRQ_ERROR_BIT] = |(flag_set & ~s_r.flags);
      // Sticky interrupt status, cleared by a read
      if (rd_ok && index == `IRQ_STATUS_IDX)
      begin
         s_nxt.irq_status = `IRQ_RST;
      end
      s_nxt.irq_status = s_nxt.irq_status | irq_set;
      s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
      s_nxt.fault_n = !(|s_nxt.flags);
      s_nxt.busy = s_nxt.phase != tof_regs_pkg::phase_idle;
      s_nxt.short_force = s_nxt.timeout_control[`TO_FORCE_BIT];
   end

   // State register
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s_r <= RESET_STATE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign readdata_out = s_r.readdata;
   assign waitrequest_out = s_r.waitrequest;
   assign fault_out_n = s_r.fault_n;
   assign irq_out = s_r.irq;
   assign timeout_out = s_r.timeout;
   assign state_reset_out = s_r.state_reset;
   assign short_flight_force_out = s_r.short_force;
   assign busy_out = s_r.busy;

   // Checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);

   property p_weak_flag;
      (s_r.phase == tof_regs_pkg::phase_listen && timer_done && wait_en && !echo_qualified_in && !clr_missing
         && s_r.crossings < expected_crossings_in) |=> s_r.flags[`ERR_WEAK_BIT] && timeout_out;
   endproperty
   a_weak_flag: assert property (p_weak_flag) else $error("weak flag not set on timeout");

   property p_missing_flag;
      (s_r.phase == tof_regs_pkg::phase_listen && timer_done && wait_en && !echo_qualified_in && !clr_missing
         && !s_r.signal_seen) |=> s_r.flags[`ERR_MISSING_BIT] && !fault_out_n;
   endproperty
   a_missing_flag: assert property (p_missing_flag) else $error("missing flag not set on timeout");

   property p_abort;
      clr_missing |=> state_reset_out && !busy_out && s_r.phase == tof_regs_pkg::phase_idle ##1 !state_reset_out;
   endproperty
   a_abort: assert property (p_abort) else $error("missing flag clear did not abort");

   property p_strong_gate;
      $rose(s_r.flags[`ERR_STRONG_BIT]) |-> $past(amplitude_over_in && echo_threshold_select_in == `THRESH_MAX);
   endproperty
   a_strong_gate: assert property (p_strong_gate) else $error("strong flag without top threshold");

   property p_clear_all;
      (clr_all && !amplitude_over_in && s_r.phase != tof_regs_pkg::phase_listen) |=> fault_out_n && s_r.flags == 3'h0;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("strong bit write did not clear flags");

   property p_force;
      (s_r.phase == tof_regs_pkg::phase_cancel && timer_done && !clr_missing)
         |=> s_r.phase == ($past(s_r.timeout_control[`TO_FORCE_BIT]) ? tof_regs_pkg::phase_blank
            : tof_regs_pkg::phase_listen);
   endproperty
   a_force: assert property (p_force) else $error("short flight force ignored");

   property p_blank_len;
      (s_r.timer_start && s_r.phase == tof_regs_pkg::phase_blank)
         |-> s_r.timer_length == (`BLANK_BASE_TICKS << s_r.timeout_control[`TO_BLANK_LSB +: 3]);
   endproperty
   a_blank_len: assert property (p_blank_len) else $error("wrong blanking length");

   property p_no_wait;
      (s_r.phase == tof_regs_pkg::phase_listen && !wait_en) |=> !timeout_out;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("timeout while disabled");

   property p_listen_len;
      (s_r.timer_start && s_r.phase == tof_regs_pkg::phase_listen)
         |-> s_r.timer_length == (`LISTEN_BASE_TICKS << s_r.timeout_control[`TO_LISTEN_LSB +: 2]);
   endproperty
   a_listen_len: assert property (p_listen_len) else $error("wrong listening length");

   property p_cancel_len;
      (s_r.timer_start && s_r.phase == tof_regs_pkg::phase_cancel)
         |-> s_r.timer_length == (`CANCEL_BASE_TICKS << s_r.clock_rate_control[`CR_CANCEL_LSB +: 2]);
   endproperty
   a_cancel_len: assert property (p_cancel_len) else $error("wrong offset cancel length");

   property p_fault_pin;
      fault_out_n == !(|s_r.flags);
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin disagrees with flags");

   c_timeout: cover property (timeout_out);
   c_abort: cover property (busy_out ##1 state_reset_out);
   c_short: cover property (s_r.phase == tof_regs_pkg::phase_blank ##1 s_r.phase == tof_regs_pkg::phase_blank);

endmodule

// ===== rtl/tof_regs_cfg.svh
// Purpose: Offsets, field positions, reset values and tick counts of the ToF register bank
// Assumes: Included by its bare name from the design files
// Notes: Offsets are register indices; the byte address is four times the index
`ifndef TOF_REGS_CFG_SVH
`define TOF_REGS_CFG_SVH

// Register indices
`define ERR_FLAGS_IDX 4'h7
`define TIMEOUT_IDX 4'h8
`define CLK_RATE_IDX 4'h9
`define IRQ_STATUS_IDX 4'hA
`define IRQ_MASK_IDX 4'hB
`define MEAS_CTRL_IDX 4'hC

// Reset values
`define TIMEOUT_RST 8'h19
`define CLK_RATE_RST 8'h00
`define FLAGS_RST 3'h0
`define IRQ_RST 3'h0
`define READDATA_RST 32'h0000_0000

// Error flag positions
`define ERR_STRONG_BIT 0
`define ERR_MISSING_BIT 1
`define ERR_WEAK_BIT 2

// Timeout control field positions
`define TO_FORCE_BIT 6
`define TO_BLANK_LSB 3
`define TO_WAIT_BIT 2
`define TO_LISTEN_LSB 0

// Clock rate control field positions
`define CR_HALVE_BIT 2
`define CR_CANCEL_LSB 0

// Measurement control bits
`define MC_START_BIT 0

// Interrupt status positions
`define IRQ_TIMEOUT_BIT 0
`define IRQ_ERROR_BIT 1
`define IRQ_DONE_BIT 2

// Base tick counts for code zero, and highest threshold code
`define BLANK_BASE_TICKS 11'h008
`define LISTEN_BASE_TICKS 11'h080
`define CANCEL_BASE_TICKS 11'h040
`define MAX_TICKS 11'h400
`define THRESH_MAX 3'h7

`endif

// ===== rtl/tof_regs_pkg.sv
// Purpose: Types shared by the ToF register bank and its tick timer
// Assumes: Constants live in tof_regs_cfg.svh
// Notes: All module state is held as one packed struct
package tof_regs_pkg;

   typedef enum logic [2:0]
   {
      phase_idle = 3'b000,
      phase_cancel = 3'b001,
      phase_blank = 3'b010,
      phase_listen = 3'b011
   } phase_type;

   typedef struct packed
   {
      logic [7:0] timeout_control;
      logic [7:0] clock_rate_control;
      logic [2:0] flags;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      phase_type phase;
      logic [2:0] crossings;
      logic signal_seen;
      logic waitrequest;
      logic [31:0] readdata;
      logic fault_n;
      logic irq;
      logic state_reset;
      logic timeout;
      logic short_force;
      logic busy;
      logic timer_start;
      logic timer_abort;
      logic [10:0] timer_length;
   } regs_state_type;

   typedef struct packed
   {
      logic halve_phase;
      logic [10:0] count;
      logic running;
      logic done;
   } timer_state_type;

endpackage

// ===== rtl/tick_timer.sv
// Purpose: Base tick generator and down counter for tick-based durations
// Assumes: Length is at least one tick and at most 1024 ticks
// Notes: Done is a one-cycle pulse after the last tick of a run
`timescale 1ns/1ps
`include "tof_regs_cfg.svh"

module tick_timer
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic halve_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic [10:0] length_in,
   output logic done_out
);

   tof_regs_pkg::timer_state_type s_r;
   tof_regs_pkg::timer_state_type s_nxt;
   logic tick;

   // Base tick every clock, or every second clock when halved
   assign tick = !halve_in || s_r.halve_phase;

   // Next state of the counter
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.halve_phase = halve_in && !s_r.halve_phase;
      if (abort_in)
      begin
         s_nxt.running = 1'b0;
      end
      else if (start_in)
      begin
         s_nxt.count = length_in;
         s_nxt.running = 1'b1;
      end
      else if (s_r.running && tick)
      begin
         if (s_r.count == 11'h001)
         begin
            s_nxt.running = 1'b0;
            s_nxt.done = 1'b1;
         end
         else
         begin
            s_nxt.count = s_r.count - 11'h001;
         end
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign done_out = s_r.done;

   // Checks on tick spacing and count range
   property p_halved_tick;
      @(posedge clock_in) disable iff (!reset_n_in)
      (halve_in && tick) ##1 halve_in |-> !tick;
   endproperty
   a_halved_tick: assert property (p_halved_tick) else $error("halved tick on two edges");

   property p_count_range;
      @(posedge clock_in) disable iff (!reset_n_in)
      s_r.running |-> (s_r.count <= `MAX_TICKS) && (s_r.count != 11'h000);
   endproperty
   a_count_range: assert property (p_count_range) else $error("tick count out of range");

endmodule

// ===== bench/host_model.sv
// Purpose: Host side bus master issuing register accesses
// Assumes: Avalon-MM slave that answers with waitrequest low
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module host_model
(
   input wire logic clock_in,
   input wire logic [31:0] readdata_in,
   input wire logic waitrequest_in,
   output logic [5:0] address_out,
   output logic read_out,
   output logic write_out,
   output logic [31:0] writedata_out,
   output logic [3:0] byteenable_out
);
   // Idle bus at time zero
   initial
   begin
      address_out = 6'h00;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h0000_0000;
      byteenable_out = 4'h0;
   end

   // One bus cycle, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock_in);
      address_out <= a;
      writedata_out <= d;
      byteenable_out <= 4'hF;
      read_out <= ~wr;
      write_out <= wr;
      // Wait for the answer; only the bench watchdog ends a hang
      do
      begin
         @(posedge clock_in);
      end
      while (waitrequest_in !== 1'b0);
      q = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      address_out <= ~a;
      writedata_out <= ~d;
      byteenable_out <= 4'h0;
   endtask

   // Status check and flag clear ahead of a measurement
   task automatic prepare(output logic [31:0] q);
      logic [31:0] dummy;
      access(1'b0, 6'h1C, 32'h0000_0000, q);
      access(1'b1, 6'h1C, 32'h0000_0001, dummy);
   endtask
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the echo error, timeout and clock registers
// Assumes: One wait cycle per access; timing windows allow a few cycles of overhead
// Notes: Event inputs are driven by the bench on the rising edge
`timescale 1ns/1ps
module testbench;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [5:0] address;
   logic rd, wr, waitrequest, fault_n, irq, timeout, state_reset, force_out, busy;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   logic meas_start = 1'b0, qual = 1'b0, sig = 1'b0, amp = 1'b0, saw_reset = 1'b0;
   logic [2:0] thresh = 3'h0, expect_n = 3'h1;
   int n_mismatch = 0, comparisons = 0;

   // Clock at 4 ns period
   always #2 clock_in = ~clock_in;
   always @(posedge clock_in) if (state_reset === 1'b1) saw_reset <= 1'b1;

   tof_error_timeout_clock_regs tof_error_timeout_clock_regs_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .address_in(address), .read_in(rd), .write_in(wr), .writedata_in(wdata), .byteenable_in(be),
      .readdata_out(rdata), .waitrequest_out(waitrequest), .meas_start_in(meas_start),
      .echo_qualified_in(qual), .echo_signal_in(sig), .amplitude_over_in(amp),
      .echo_threshold_select_in(thresh), .expected_crossings_in(expect_n), .fault_out_n(fault_n),
      .irq_out(irq), .timeout_out(timeout), .state_reset_out(state_reset),
      .short_flight_force_out(force_out), .busy_out(busy));
   host_model host_model_i (.clock_in(clock_in), .readdata_in(rdata), .waitrequest_in(waitrequest),
      .address_out(address), .read_out(rd), .write_out(wr), .writedata_out(wdata), .byteenable_out(be));

   // Value comparison
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      host_model_i.access(1'b1, a, d, q);
   endtask

   // Start pulse, then count cycles until timeout pulse
   task automatic measure(output int n);
      @(posedge clock_in) meas_start <= 1'b1;
      @(posedge clock_in) meas_start <= 1'b0;
      n = 0;
      while (timeout !== 1'b1 && n < 3000)
      begin
         @(posedge clock_in);
         n++;
      end
   endtask

   // Reset values and unmapped read
   task automatic t_reset();
      host_model_i.access(1'b0, 6'h20, 32'h0, q);
      check(q, 32'h0000_0019);
      host_model_i.access(1'b0, 6'h24, 32'h0, q);
      check(q, 32'h0000_0000);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0000);
      host_model_i.access(1'b0, 6'h3C, 32'h0, q);
      check(q, 32'h0000_0000);
      check(fault_n, 1'b1);
      $display("test reset done");
   endtask

   // Timed run without signal: duration, flags and fault pin
   task automatic t_timed(input logic [7:0] cr, input logic [7:0] to, input int ticks);
      int n;
      host_model_i.prepare(q);
      wr_reg(6'h24, {24'h0, cr});
      wr_reg(6'h20, {24'h0, to});
      measure(n);
      check(n >= ticks - 2 && n <= ticks + 8, 1'b1);
      check(force_out, to[6]);
      @(posedge clock_in);
      check(fault_n, 1'b0);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0006);
      $display("test timed run done");
   endtask

   // Interrupt on error, read clears status
   task automatic t_irq();
      int n;
      host_model_i.prepare(q);
      wr_reg(6'h2C, 32'h0000_0003);
      measure(n);
      @(posedge clock_in);
      check(irq, 1'b1);
      host_model_i.access(1'b0, 6'h28, 32'h0, q);
      check(q, 32'h0000_0003);
      @(posedge clock_in);
      check(irq, 1'b0);
      wr_reg(6'h1C, 32'h0000_0001);
      @(posedge clock_in);
      check(fault_n, 1'b1);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0000);
      $display("test irq done");
   endtask

   // Too few crossings with signal present
   task automatic t_weak();
      int n;
      host_model_i.prepare(q);
      expect_n <= 3'h3;
      @(posedge clock_in) meas_start <= 1'b1;
      @(posedge clock_in) meas_start <= 1'b0;
      q = 32'h0;
      for (n = 0; n < 1000 && q[2:0] !== 3'h3; n++)
         host_model_i.access(1'b0, 6'h30, 32'h0, q);
      @(posedge clock_in) sig <= 1'b1;
      qual <= 1'b1;
      @(posedge clock_in) sig <= 1'b0;
      qual <= 1'b0;
      @(posedge clock_in) qual <= 1'b1;
      @(posedge clock_in) qual <= 1'b0;
      for (n = 0; n < 3000 && timeout !== 1'b1; n++)
         @(posedge clock_in);
      @(posedge clock_in);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0004);
      expect_n <= 3'h1;
      $display("test weak done");
   endtask

   // Strong flag only at the top threshold code
   task automatic t_strong();
      host_model_i.prepare(q);
      thresh <= 3'h6;
      amp <= 1'b1;
      repeat (3) @(posedge clock_in);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0000);
      thresh <= 3'h7;
      repeat (3) @(posedge clock_in);
      amp <= 1'b0;
      @(posedge clock_in);
      check(fault_n, 1'b0);
      host_model_i.access(1'b0, 6'h1C, 32'h0, q);
      check(q, 32'h0000_0001);
      $display("test strong done");
   endtask

   // Timeout disabled, then abort by missing-echo write
   task automatic t_abort();
      int n;
      host_model_i.prepare(q);
      wr_reg(6'h20, 32'h0000_0004);
      // Start through the measurement register this time
      wr_reg(6'h30, 32'h0000_0001);
      for (n = 0; n < 3000 && timeout !== 1'b1; n++)
         @(posedge clock_in);
      check(n, 3000);
      check(busy, 1'b1);
      check(saw_reset, 1'b0);
      wr_reg(6'h1C, 32'h0000_0002);
      repeat (2) @(posedge clock_in);
      check(saw_reset, 1'b1);
      check(busy, 1'b0);
      $display("test abort done");
   endtask

   // Watchdog
   initial
   begin
      #200000;
      n_mismatch++;
      final_report();
   end

   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      t_reset();
      t_irq();
      t_timed(8'h00, 8'h00, 192);
      t_timed(8'h04, 8'h00, 384);
      t_timed(8'h03, 8'h03, 1536);
      t_timed(8'h00, 8'h40, 200);
      t_timed(8'h00, 8'h78, 1216);
      t_weak();
      t_strong();
      t_abort();
      final_report();
   end
endmodule
